// File: design/tcc_defines.vh
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// Register byte offsets
`define TCC_OFF_CHAN_CS 8'h00
`define TCC_OFF_IRQ_STATUS 8'h04
`define TCC_OFF_IRQ_MASK 8'h08
`define TCC_OFF_UNIT_CTRL 8'h0c

// Channel control/status field positions
`define TCC_BIT_FLAG 7
`define TCC_BIT_IE 6
`define TCC_BIT_MSU 5
`define TCC_BIT_MSL 4
`define TCC_ELS_HI 3
`define TCC_ELS_LO 2

// Unit control and interrupt status field positions
`define TCC_BIT_CPWM 0
`define TCC_BIT_EVT 0

// Reset values
`define TCC_RST_CHAN_CS 8'h00
`define TCC_RST_IRQ_MASK 1'b0
`define TCC_RST_CPWM 1'b0

// Edge/level select codes
`define TCC_ELS_OFF 2'h0
`define TCC_ELS_01 2'h1
`define TCC_ELS_10 2'h2
`define TCC_ELS_11 2'h3

// Decoded channel modes
`define TCC_MODE_IC 2'h0
`define TCC_MODE_OC 2'h1
`define TCC_MODE_EPWM 2'h2
`define TCC_MODE_CPWM 2'h3

`endif

// File: design/tcc_pin_sync.v
`timescale 1ns/10ps
// Three-stage pin synchroniser with a stable level that only moves when
// stages two and three agree, plus one-cycle edge pulses.
module tcc_pin_sync
(
   input wire pclk,
   input wire presetn,
   input wire pclk_en,
   input wire pin_async,
   output reg pin_level,
   output wire pin_rise,
   output wire pin_fall
);

   reg stage1;
   reg stage2;
   reg stage3;
   reg level_prev;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         pin_level <= 1'b0;
         level_prev <= 1'b0;
      end
      else if (pclk_en)
      begin
         stage1 <= pin_async;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3)
            pin_level <= stage3;
         level_prev <= pin_level;
      end
   end

   assign pin_rise = pin_level & ~level_prev;
   assign pin_fall = ~pin_level & level_prev;

endmodule // tcc_pin_sync

// File: design/tcc_channel_ctrl.v
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "tcc_defines.vh"

module tcc_channel_ctrl
(
   input wire pclk,
   input wire presetn,
   input wire pclk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   input wire counter_match,
   input wire counter_wrap,
   input wire counter_up,
   input wire chan_pin_in,
   output reg chan_pin_out,
   output wire chan_pin_oe,
   output wire pin_released,
   output wire capture_strobe,
   output wire coherency_reset,
   output wire center_pwm_select,
   output wire chan_irq,
   output wire irq
);

   // Channel control/status fields
   reg channel_event_flag;
   reg channel_irq_enable;
   reg mode_select_upper;
   reg mode_select_lower;
   reg [1:0] edge_level_select;

   // Block-level registers
   reg center_pwm;
   reg irq_status;
   reg irq_mask;

   // Clear handshake: armed by a read that saw the flag set
   reg clear_armed;

   reg [1:0] chan_mode;
   reg chan_event;
   reg capture_hit;
   reg next_pin;
   reg [31:0] next_rdata;

   wire pin_level;
   wire pin_rise;
   wire pin_fall;

   wire setup_phase;
   wire access_done;
   wire wr_done;
   wire rd_done;
   wire addr_hit;
   wire wr_cs;
   wire rd_cs;
   wire wr_status;
   wire wr_mask;
   wire wr_ctrl;
   wire sw_clear;
   wire pin_used;

   tcc_pin_sync u_pin_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .pclk_en(pclk_en),
      .pin_async(chan_pin_in),
      .pin_level(pin_level),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall)
   );

   // APB handshake; a frozen clock enable stretches the access phase
   assign pready = pclk_en;
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pclk_en;
   assign wr_done = access_done & pwrite;
   assign rd_done = access_done & ~pwrite;

   assign addr_hit = (paddr == `TCC_OFF_CHAN_CS) || (paddr == `TCC_OFF_IRQ_STATUS) ||
                     (paddr == `TCC_OFF_IRQ_MASK) || (paddr == `TCC_OFF_UNIT_CTRL);
   assign pslverr = psel & penable & ~addr_hit;

   assign wr_cs = wr_done & (paddr == `TCC_OFF_CHAN_CS);
   assign rd_cs = rd_done & (paddr == `TCC_OFF_CHAN_CS);
   assign wr_status = wr_done & (paddr == `TCC_OFF_IRQ_STATUS);
   assign wr_mask = wr_done & (paddr == `TCC_OFF_IRQ_MASK);
   assign wr_ctrl = wr_done & (paddr == `TCC_OFF_UNIT_CTRL);

   // Mode decode: center select overrides the per-channel bits
   always @*
   begin
      if (center_pwm)
         chan_mode = `TCC_MODE_CPWM;
      else if (mode_select_upper)
         chan_mode = `TCC_MODE_EPWM;
      else if (mode_select_lower)
         chan_mode = `TCC_MODE_OC;
      else
         chan_mode = `TCC_MODE_IC;
   end

   assign pin_used = (edge_level_select != `TCC_ELS_OFF);
   assign pin_released = ~pin_used;

   // Active edge detection; a pin that moves while the mode changes can
   // still look like an edge, which software is expected to clean up
   always @*
   begin
      case (edge_level_select)
         `TCC_ELS_01: capture_hit = pin_rise;
         `TCC_ELS_10: capture_hit = pin_fall;
         `TCC_ELS_11: capture_hit = pin_rise | pin_fall;
         default: capture_hit = 1'b0;
      endcase
      if (chan_mode != `TCC_MODE_IC)
         capture_hit = 1'b0;
   end

   // Strobe is gated by the enable so a frozen block never captures
   assign capture_strobe = capture_hit & pclk_en;

   // Channel event per mode
   always @*
   begin
      case (chan_mode)
         `TCC_MODE_IC: chan_event = capture_hit;
         `TCC_MODE_OC: chan_event = counter_match;
         `TCC_MODE_EPWM: chan_event = counter_match;
         `TCC_MODE_CPWM: chan_event = counter_match;
         default: chan_event = 1'b0;
      endcase
   end

   // Pin action per mode
   always @*
   begin
      next_pin = chan_pin_out;
      case (chan_mode)
         `TCC_MODE_OC:
         begin
            if (counter_match)
            begin
               case (edge_level_select)
                  `TCC_ELS_01: next_pin = ~chan_pin_out;
                  `TCC_ELS_10: next_pin = 1'b0;
                  `TCC_ELS_11: next_pin = 1'b1;
                  default: next_pin = chan_pin_out;
               endcase
            end
         end
         `TCC_MODE_EPWM:
         begin
            // Period start drives the inactive-to-active level; the match
            // ends the pulse
            if (counter_match)
               next_pin = edge_level_select[0];
            else if (counter_wrap)
               next_pin = ~edge_level_select[0];
         end
         `TCC_MODE_CPWM:
         begin
            if (counter_match)
            begin
               if (counter_up)
                  next_pin = edge_level_select[0];
               else
                  next_pin = ~edge_level_select[0];
            end
         end
         default: next_pin = chan_pin_out;
      endcase
      if (!pin_used)
         next_pin = 1'b0;
   end

   assign chan_pin_oe = pin_used & (chan_mode != `TCC_MODE_IC);

   // Clearing is only legal after an armed read, and a fresh event in the
   // same cycle wins so no request is ever dropped
   assign sw_clear = wr_cs & clear_armed & ~pwdata[`TCC_BIT_FLAG] & ~chan_event;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         channel_event_flag <= 1'b0;
         channel_irq_enable <= 1'b0;
         mode_select_upper <= 1'b0;
         mode_select_lower <= 1'b0;
         edge_level_select <= `TCC_ELS_OFF;
         clear_armed <= 1'b0;
      end
      else if (pclk_en)
      begin
         if (chan_event)
            channel_event_flag <= 1'b1;
         else if (sw_clear)
            channel_event_flag <= 1'b0;
         // Writing one leaves the flag as it is
         if (chan_event)
            clear_armed <= 1'b0;
         else if (rd_cs)
            clear_armed <= channel_event_flag;
         else if (wr_cs)
            clear_armed <= 1'b0;
         if (wr_cs)
         begin
            channel_irq_enable <= pwdata[`TCC_BIT_IE];
            mode_select_upper <= pwdata[`TCC_BIT_MSU];
            mode_select_lower <= pwdata[`TCC_BIT_MSL];
            edge_level_select <= pwdata[`TCC_ELS_HI:`TCC_ELS_LO];
         end
      end
   end

   assign coherency_reset = wr_cs;
   assign chan_irq = channel_event_flag & channel_irq_enable;

   // Block registers, sticky status with write-one-to-clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         center_pwm <= `TCC_RST_CPWM;
         irq_mask <= `TCC_RST_IRQ_MASK;
         irq_status <= 1'b0;
         chan_pin_out <= 1'b0;
      end
      else if (pclk_en)
      begin
         if (wr_ctrl)
            center_pwm <= pwdata[`TCC_BIT_CPWM];
         if (wr_mask)
            irq_mask <= pwdata[`TCC_BIT_EVT];
         if (chan_event)
            irq_status <= 1'b1;
         else if (wr_status & pwdata[`TCC_BIT_EVT])
            irq_status <= 1'b0;
         chan_pin_out <= next_pin;
      end
   end

   assign center_pwm_select = center_pwm;
   assign irq = irq_status & irq_mask;

   // Read data is captured in the setup phase so prdata comes from a flop
   always @*
   begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         `TCC_OFF_CHAN_CS:
         begin
            next_rdata[`TCC_BIT_FLAG] = channel_event_flag;
            next_rdata[`TCC_BIT_IE] = channel_irq_enable;
            next_rdata[`TCC_BIT_MSU] = mode_select_upper;
            next_rdata[`TCC_BIT_MSL] = mode_select_lower;
            next_rdata[`TCC_ELS_HI:`TCC_ELS_LO] = edge_level_select;
         end
         `TCC_OFF_IRQ_STATUS: next_rdata[`TCC_BIT_EVT] = irq_status;
         `TCC_OFF_IRQ_MASK: next_rdata[`TCC_BIT_EVT] = irq_mask;
         `TCC_OFF_UNIT_CTRL: next_rdata[`TCC_BIT_CPWM] = center_pwm;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (pclk_en && setup_phase && !pwrite)
         prdata <= next_rdata;
   end

endmodule // tcc_channel_ctrl

// File: test/tcc_channel_ctrl_asserts.sv
`timescale 1ns/10ps
module tcc_channel_ctrl_chk
(
   input wire pclk,
   input wire presetn,
   input wire pclk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire counter_match,
   input wire counter_wrap,
   input wire chan_pin_out,
   input wire chan_pin_oe,
   input wire pin_released,
   input wire capture_strobe,
   input wire coherency_reset,
   input wire center_pwm_select,
   input wire chan_irq,
   input wire irq
);
   wire any_wr = psel && penable && pwrite && pclk_en;
   wire cs_wr = any_wr && paddr == 8'h00;
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_pin_release:
      assert property (pin_released |-> !chan_pin_oe) else $error("released pin driven");
   chk_pin_low:
      assert property (pin_released && $past(pin_released) |-> !chan_pin_out) else $error("released pin not low");
   chk_coh_reset:
      assert property (cs_wr |-> coherency_reset) else $error("no latch reset on write");
   chk_irq_reset:
      assert property ($rose(presetn) |-> !chan_irq) else $error("irq after reset");
   chk_irq_cause:
      assert property ($rose(chan_irq) |-> $past(capture_strobe || counter_match || cs_wr)) else $error("irq no cause");
   chk_flag_clear:
      assert property ($fell(chan_irq) |-> $past(cs_wr)) else $error("irq fell without write");
   chk_cpwm_write:
      assert property ($changed(center_pwm_select) |-> $past(any_wr && paddr == 8'h0c)) else $error("center sel moved");
   chk_strobe_mode:
      assert property (capture_strobe |-> !chan_pin_oe && !pin_released) else $error("strobe outside capture");
   chk_pin_cause:
      assert property ($changed(chan_pin_out) |-> $past(counter_match || counter_wrap || any_wr) || $past(any_wr, 2))
         else $error("pin moved without cause");
   chk_line_cause:
      assert property ($rose(irq) |-> $past(capture_strobe || counter_match || any_wr)) else $error("line no cause");
endmodule // tcc_channel_ctrl_chk
bind tcc_channel_ctrl tcc_channel_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .counter_match(counter_match), .counter_wrap(counter_wrap),
   .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe), .pin_released(pin_released),
   .capture_strobe(capture_strobe), .coherency_reset(coherency_reset), .center_pwm_select(center_pwm_select),
   .chan_irq(chan_irq), .irq(irq));

// File: test/timer_channel1_ctrl_status_test.sv
`timescale 1ns/10ps
module timer_channel1_ctrl_status_test;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg pclk_en = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   reg counter_match = 1'b0;
   reg counter_wrap = 1'b0;
   reg counter_up = 1'b1;
   reg chan_pin_in = 1'b0;
   reg [31:0] rdv;
   reg errv;
   wire [31:0] prdata;
   wire pready, pslverr, chan_pin_out, chan_pin_oe, pin_released, capture_strobe, coh, cpwm, chan_irq, irq;
   integer n_mismatch = 0;
   integer cmp_count = 0;
   integer i;
   always #25 pclk = ~pclk;
   tcc_channel_ctrl u_tcc_channel_ctrl (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .counter_match(counter_match), .counter_wrap(counter_wrap), .counter_up(counter_up),
      .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
      .pin_released(pin_released), .capture_strobe(capture_strobe), .coherency_reset(coh),
      .center_pwm_select(cpwm), .chan_irq(chan_irq), .irq(irq));
   task results;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Every bus and stimulus task ends at a falling edge so outputs are settled when compared
   task xfer(input w, input [7:0] a, input [31:0] d);
      integer k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge pclk);
         k = k + 1;
      end
      if (k >= 20)
      begin
         n_mismatch = n_mismatch + 1;
         results;
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask
   task rd_chk(input [7:0] a, input [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask
   task clr(input [31:0] cs);
      xfer(1'b0, 8'h00, 32'h0);
      xfer(1'b1, 8'h00, cs);
   endtask
   task ev(input m, input w);
      @(posedge pclk);
      counter_match <= m;
      counter_wrap <= w;
      @(posedge pclk);
      counter_match <= 1'b0;
      counter_wrap <= 1'b0;
      @(negedge pclk);
   endtask
   task mode_ev(input [31:0] cs, input m, input w, input exp);
      xfer(1'b1, 8'h00, cs);
      ev(m, w);
      chk(chan_pin_out, exp);
   endtask
   task pin(input v);
      @(posedge pclk);
      chan_pin_in <= v;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
   endtask
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(8'h00, 32'h0);
      rd_chk(8'h04, 32'h0);
      rd_chk(8'h08, 32'h0);
      rd_chk(8'h0c, 32'h0);
      xfer(1'b0, 8'h10, 32'h0);
      chk(errv, 1'b1);
      xfer(1'b1, 8'h00, 32'hff);
      rd_chk(8'h00, 32'h7c);
      for (i = 0; i < 8; i = i + 1)
      begin
         xfer(1'b1, 8'h00, {24'h0, 2'h0, i[1:0], {2{i[2]}}, 2'h0});
         chk(pin_released, !i[2]);
         chk(chan_pin_oe, i[2] && i[1:0] != 2'h0);
      end
      mode_ev(32'h5c, 1'b1, 1'b0, 1'b1);
      chk(chan_irq, 1'b1);
      mode_ev(32'h54, 1'b1, 1'b0, 1'b0);
      mode_ev(32'h54, 1'b1, 1'b0, 1'b1);
      mode_ev(32'h58, 1'b1, 1'b0, 1'b0);
      mode_ev(32'h50, 1'b1, 1'b0, 1'b0);
      xfer(1'b1, 8'h00, 32'h50);
      rd_chk(8'h00, 32'hd0);
      ev(1'b1, 1'b0);
      xfer(1'b1, 8'h00, 32'h50);
      rd_chk(8'h00, 32'hd0);
      xfer(1'b1, 8'h00, 32'hd0);
      rd_chk(8'h00, 32'hd0);
      xfer(1'b1, 8'h00, 32'h50);
      rd_chk(8'h00, 32'h50);
      chk(chan_irq, 1'b0);
      xfer(1'b1, 8'h00, 32'h10);
      ev(1'b1, 1'b0);
      chk(chan_irq, 1'b0);
      rd_chk(8'h00, 32'h90);
      rd_chk(8'h04, 32'h1);
      chk(irq, 1'b0);
      xfer(1'b1, 8'h08, 32'h1);
      chk(irq, 1'b1);
      xfer(1'b1, 8'h04, 32'h1);
      chk(irq, 1'b0);
      mode_ev(32'h28, 1'b0, 1'b1, 1'b1);
      mode_ev(32'h28, 1'b1, 1'b0, 1'b0);
      mode_ev(32'h24, 1'b0, 1'b1, 1'b0);
      mode_ev(32'h24, 1'b1, 1'b0, 1'b1);
      for (i = 1; i < 4; i = i + 1)
      begin
         clr(i << 2);
         pin(1'b1);
         rd_chk(8'h00, {24'h0, i[0], 3'h0, i[1:0], 2'h0});
         clr(i << 2);
         pin(1'b0);
         rd_chk(8'h00, {24'h0, i[1], 3'h0, i[1:0], 2'h0});
      end
      xfer(1'b1, 8'h0c, 32'h1);
      chk(cpwm, 1'b1);
      mode_ev(32'h0c, 1'b1, 1'b0, 1'b1);
      chk(chan_pin_oe, 1'b1);
      mode_ev(32'h08, 1'b1, 1'b0, 1'b0);
      clr(32'h08);
      @(posedge pclk);
      counter_up <= 1'b0;
      ev(1'b1, 1'b0);
      chk(chan_pin_out, 1'b1);
      rd_chk(8'h00, 32'h88);
      results;
   end
endmodule // timer_channel1_ctrl_status_test
